// ==== design/gccd_top.sv ====
`timescale 1ns/10ps
module gccd_top #(
    parameter int NCH = 3
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    // AXI4-Lite slave
    input  wire logic [9:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // Read address and read answer
    input  wire logic [9:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Converter side, same clock
    input  wire logic                 mod_tick,
    input  wire logic                 chop_swap,
    input  wire logic                 conv_valid,
    input  wire logic [NCH*24-1:0]    ch_data,
    // Configuration views and events
    output logic [7:0]                ch0_gain,
    output logic                      chop_on,
    output logic                      measuring,
    output logic                      detect_flag,
    output logic                      irq
);
    import gccd_pkg::*;

    // Register storage
    logic [15:0] gain_q;
    logic [15:0] rsvd_q;
    logic [15:0] cfg_q;
    logic [15:0] th_high_q;
    logic [15:0] th_low_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_mask_q;

    // Write path holding state
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_idx_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_hit;
    logic [15:0] wmask;
    logic [15:0] wval;

    // Read decode
    logic [7:0]  ar_idx;
    logic [15:0] rd_val;
    logic        rd_hit;

    // Field views
    logic [2:0]  ch0_gain_code;
    logic [3:0]  chop_delay_code;
    logic        detect_all_channels;
    logic [2:0]  detect_exceed_count;
    logic [2:0]  detect_window_length;
    logic        detect_on;
    logic [15:0] detect_threshold_high;
    logic [7:0]  detect_threshold_low;
    logic [23:0] threshold;

    // Engine events and status
    logic        settled;
    logic        det_pulse;
    logic        win_busy;
    logic        conv_ok;
    logic [1:0]  stat_clr;
    logic [1:0]  stat_set;

    // Field extraction from the configuration words
    assign ch0_gain_code         = gain_q[GAIN0_LSB +: 3];
    assign chop_delay_code       = cfg_q[CFG_DLY_LSB +: 4];
    assign detect_all_channels   = cfg_q[CFG_ALLCH];
    assign detect_exceed_count   = cfg_q[CFG_NUM_LSB +: 3];
    assign detect_window_length  = cfg_q[CFG_LEN_LSB +: 3];
    assign detect_on             = cfg_q[CFG_DET];
    assign detect_threshold_high = th_high_q;
    assign detect_threshold_low  = th_low_q[TH_LOW_LSB +: 8];
    assign threshold             = {detect_threshold_high, detect_threshold_low};
    assign chop_on               = cfg_q[CFG_CHOP];

    // Only conversions taken while measuring count toward a window
    // Conversions during a chop pause are dropped
    assign conv_ok = conv_valid && measuring;

    // Gain factor presented as a register output
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ch0_gain <= 8'h01;
        end else begin
            ch0_gain <= gccd_pow2(ch0_gain_code);
        end
    end

    // Pause timer after a chop swap
    gccd_chop_timer u_chop (
        .mclk       (mclk),
        .nrst       (nrst),
        .chop_on    (chop_on),
        .chop_swap  (chop_swap),
        .mod_tick   (mod_tick),
        .delay_code (chop_delay_code),
        .measuring  (measuring),
        .settled    (settled)
    );

    // Threshold counting engine
    gccd_detect #(
        .NCH (NCH)
    ) u_detect (
        .mclk                 (mclk),
        .nrst                 (nrst),
        .detect_on            (detect_on),
        .detect_all_channels  (detect_all_channels),
        .detect_exceed_count  (detect_exceed_count),
        .detect_window_length (detect_window_length),
        .threshold            (threshold),
        .conv_ok              (conv_ok),
        .ch_data              (ch_data),
        .detect_pulse         (det_pulse),
        .window_busy          (win_busy)
    );

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

    // Address half held until data is in
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[9:2];
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    // Data half held the same way
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    // Byte lanes 0 and 1 cover the sixteen-bit registers
    // Lanes 2 and 3 are ignored
    assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wval  = w_data_q[15:0];

    always_comb begin
        // Live word answers OKAY, drops data
        case (aw_idx_q)
            IDX_GAIN, IDX_RSVD, IDX_CFG, IDX_TH_HIGH, IDX_TH_LOW,
            IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_LIVE: wr_hit = 1'b1;
            default:                              wr_hit = 1'b0;
        endcase
    end

    // Write response; unmapped addresses answer with a slave error
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration registers, one merge per byte lane
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gain_q    <= RST_GAIN;
            rsvd_q    <= RST_RSVD;
            cfg_q     <= RST_CFG;
            th_high_q <= RST_TH_HIGH;
            th_low_q  <= RST_TH_LOW;
        end else if (wr_fire) begin
            // Other indices leave storage alone
            case (aw_idx_q)
                IDX_GAIN:    gain_q    <= (gain_q & ~wmask) | (wval & wmask);
                IDX_RSVD:    rsvd_q    <= (rsvd_q & ~wmask) | (wval & wmask);
                IDX_CFG:     cfg_q     <= (cfg_q & ~wmask) | (wval & wmask);
                IDX_TH_HIGH: th_high_q <= (th_high_q & ~wmask) | (wval & wmask);
                IDX_TH_LOW:  th_low_q  <= (th_low_q & ~wmask) | (wval & wmask);
                default:     gain_q    <= gain_q;
            endcase
        end
    end

    // Interrupt mask
    // Both bits sit in lane 0
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_q <= RST_IRQ;
        end else if (wr_fire && aw_idx_q == IDX_IRQ_MASK && w_strb_q[0]) begin
            irq_mask_q <= w_data_q[1:0];
        end
    end

    // Write-one clear and events
    always_comb begin
        stat_clr = 2'h0;
        if (wr_fire && aw_idx_q == IDX_IRQ_STAT && w_strb_q[0]) begin
            stat_clr = w_data_q[1:0];
        end
        stat_set              = 2'h0;
        stat_set[IRQ_DETECT]  = det_pulse;
        stat_set[IRQ_SETTLED] = settled;
    end

    // Sticky status; a new event beats a write-one clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_q <= RST_IRQ;
        end else begin
            irq_stat_q <= (irq_stat_q & ~stat_clr) | stat_set;
        end
    end

    // Level until cleared or masked
    assign irq         = |(irq_stat_q & irq_mask_q);
    assign detect_flag = irq_stat_q[IRQ_DETECT];

    // Read channel: one outstanding read, data registered
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_idx        = s_axi_araddr[9:2];

    always_comb begin
        rd_hit = 1'b1;
        case (ar_idx)
            IDX_GAIN:     rd_val = gain_q;
            IDX_RSVD:     rd_val = rsvd_q;
            IDX_CFG:      rd_val = cfg_q;
            IDX_TH_HIGH:  rd_val = th_high_q;
            IDX_TH_LOW:   rd_val = th_low_q;
            IDX_IRQ_STAT: rd_val = {14'h0000, irq_stat_q};
            IDX_IRQ_MASK: rd_val = {14'h0000, irq_mask_q};
            // Live view is read-only
            IDX_LIVE:     rd_val = {12'h000, win_busy, chop_on, measuring, irq};
            default: begin
                rd_val = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Payload frozen while the master stalls
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata  <= {16'h0000, rd_val};
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end
endmodule

// ==== design/gccd_pkg.sv ====
package gccd_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_GAIN     = 8'h04;
    localparam logic [7:0] IDX_RSVD     = 8'h05;
    localparam logic [7:0] IDX_CFG      = 8'h06;
    localparam logic [7:0] IDX_TH_HIGH  = 8'h07;
    localparam logic [7:0] IDX_TH_LOW   = 8'h08;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
    localparam logic [7:0] IDX_LIVE     = 8'h12;

    // Reset values
    localparam logic [15:0] RST_GAIN    = 16'h0000;
    localparam logic [15:0] RST_RSVD    = 16'h0000;
    localparam logic [15:0] RST_CFG     = 16'h0600;
    localparam logic [15:0] RST_TH_HIGH = 16'h0000;
    localparam logic [15:0] RST_TH_LOW  = 16'h0000;
    localparam logic [1:0]  RST_IRQ     = 2'h0;

    // Field positions
    localparam int GAIN0_LSB   = 0;
    localparam int CFG_DLY_LSB = 9;
    localparam int CFG_CHOP    = 8;
    localparam int CFG_ALLCH   = 7;
    localparam int CFG_NUM_LSB = 4;
    localparam int CFG_LEN_LSB = 1;
    localparam int CFG_DET     = 0;
    localparam int TH_LOW_LSB  = 8;
    localparam int IRQ_DETECT  = 0;
    localparam int IRQ_SETTLED = 1;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One-hot power of two for a three-bit code: gain and exceed count
    function automatic logic [7:0] gccd_pow2(input logic [2:0] code);
        gccd_pow2 = 8'h01 << code;
    endfunction

    // Measurement window length in conversion periods
    function automatic logic [11:0] gccd_win_len(input logic [2:0] code);
        case (code)
            3'h0:    gccd_win_len = 12'h080;
            3'h1:    gccd_win_len = 12'h100;
            3'h2:    gccd_win_len = 12'h200;
            3'h3:    gccd_win_len = 12'h300;
            3'h4:    gccd_win_len = 12'h500;
            3'h5:    gccd_win_len = 12'h700;
            3'h6:    gccd_win_len = 12'hA00;
            default: gccd_win_len = 12'hE00;
        endcase
    endfunction
endpackage

// ==== design/gccd_chop_timer.sv ====
`timescale 1ns/10ps
module gccd_chop_timer (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 chop_on,
    input  wire logic                 chop_swap,
    input  wire logic                 mod_tick,
    input  wire logic [3:0]           delay_code,
    output logic                      measuring,
    output logic                      settled
);
    import gccd_pkg::*;

    typedef enum logic [1:0] {
        GCCD_RUN  = 2'b01,
        GCCD_WAIT = 2'b10
    } gccd_chop_st_t;

    gccd_chop_st_t st_q;
    logic [16:0]   cnt_q;
    logic [16:0]   target;

    // Delay of 2^(code+1) modulator periods
    assign target    = 17'h00002 << delay_code;
    assign measuring = (st_q == GCCD_RUN);

    // Phase swap stalls measurement until the delay expires
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q    <= GCCD_RUN;
            cnt_q   <= 17'h00000;
            settled <= 1'b0;
        end else begin
            settled <= 1'b0;
            case (st_q)
                GCCD_RUN: begin
                    if (chop_on && chop_swap) begin
                        st_q  <= GCCD_WAIT;
                        cnt_q <= 17'h00000;
                    end
                end
                GCCD_WAIT: begin
                    if (!chop_on) begin
                        st_q <= GCCD_RUN;
                    end else if (chop_swap) begin
                        cnt_q <= 17'h00000;
                    end else if (mod_tick) begin
                        if (cnt_q + 17'h00001 >= target) begin
                            st_q    <= GCCD_RUN;
                            settled <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 17'h00001;
                        end
                    end
                end
                default: st_q <= GCCD_RUN;
            endcase
        end
    end
endmodule

// ==== design/gccd_detect.sv ====
`timescale 1ns/10ps
module gccd_detect #(
    parameter int NCH = 3
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 detect_on,
    input  wire logic                 detect_all_channels,
    input  wire logic [2:0]           detect_exceed_count,
    input  wire logic [2:0]           detect_window_length,
    input  wire logic [23:0]          threshold,
    input  wire logic                 conv_ok,
    input  wire logic [NCH*24-1:0]    ch_data,
    output logic                      detect_pulse,
    output logic                      window_busy
);
    import gccd_pkg::*;

    logic [11:0]    win_q;
    logic [8:0]     exc_q [NCH];
    logic [NCH-1:0] over;
    logic [NCH-1:0] qual;
    logic [8:0]     need;
    logic           hit;
    logic           done_q;
    logic           win_end;

    // Magnitude above threshold per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            logic [23:0] s;
            logic [23:0] mag;
            s      = ch_data[i*24 +: 24];
            mag    = s[23] ? (~s + 24'h000001) : s;
            over[i] = (mag > threshold);
            qual[i] = (exc_q[i] >= need);
        end
    end

    assign need    = {1'b0, gccd_pow2(detect_exceed_count)};
    assign hit     = detect_all_channels ? &qual : |qual;
    assign win_end = conv_ok && (win_q + 12'h001 >= gccd_win_len(detect_window_length));
    assign window_busy = detect_on;

    // Window and exceedance counters, cleared at each window end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            win_q <= 12'h000;
            for (int i = 0; i < NCH; i++) exc_q[i] <= 9'h000;
        end else if (!detect_on || win_end) begin
            win_q <= 12'h000;
            for (int i = 0; i < NCH; i++) exc_q[i] <= 9'h000;
        end else if (conv_ok) begin
            win_q <= win_q + 12'h001;
            for (int i = 0; i < NCH; i++) begin
                if (over[i] && exc_q[i] != 9'h1FF) exc_q[i] <= exc_q[i] + 9'h001;
            end
        end
    end

    // One detection per window
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            done_q       <= 1'b0;
            detect_pulse <= 1'b0;
        end else begin
            detect_pulse <= detect_on && hit && !done_q;
            if (!detect_on || win_end) done_q <= 1'b0;
            else if (hit) done_q <= 1'b1;
        end
    end
endmodule

// ==== sim/gccd_properties.sv ====
`timescale 1ns/10ps
module gccd_properties (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        chop_swap,
    input wire logic        chop_on,
    input wire logic        measuring,
    input wire logic        detect_flag,
    input wire logic [7:0]  ch0_gain
);
    import gccd_pkg::*;

    // One clock domain, so one clocking and one reset for all
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Gain output is always a single power of two
    property p_gain_onehot;
        $onehot(ch0_gain);
    endproperty
    a_gain_onehot: assert property (p_gain_onehot) else $error("gain not one-hot");

    // Gain only moves around a write answer
    property p_gain_by_write;
        $changed(ch0_gain) |-> (s_axi_bvalid || $past(s_axi_bvalid));
    endproperty
    a_gain_by_write: assert property (p_gain_by_write) else $error("gain moved without write");

    // Write answer two edges after both halves are taken
    property p_write_lat;
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_write_lat: assert property (p_write_lat) else $error("write answer late");

    // Write answer stands until accepted
    property p_bhold;
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");

    // Read answer one edge after address taken
    property p_read_lat;
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read answer late");

    // Read data frozen while not accepted
    property p_rhold;
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");

    // Accepted answer is withdrawn, not repeated
    property p_ar_block;
        (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read answer not withdrawn");

    // Measurement pauses only after a swap with chopping on
    property p_pause_cause;
        $fell(measuring) |-> $past(chop_swap) && $past(chop_on);
    endproperty
    a_pause_cause: assert property (p_pause_cause) else $error("pause without swap");

    // Sticky detection only clears through a write
    property p_detect_sticky;
        $fell(detect_flag) |-> $rose(s_axi_bvalid);
    endproperty
    a_detect_sticky: assert property (p_detect_sticky) else $error("detection lost");

    c_detect: cover property ($rose(detect_flag));
    c_pause: cover property ($fell(measuring));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind gccd_top gccd_properties u_props (.mclk(mclk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chop_swap(chop_swap), .chop_on(chop_on),
    .measuring(measuring), .detect_flag(detect_flag), .ch0_gain(ch0_gain));

// ==== sim/tb_gain_chop_current_detect_cfg.sv ====
`timescale 1ns/10ps
module tb_gain_chop_current_detect_cfg;
    import gccd_pkg::*;

    logic        mclk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, mod_tick, chop_swap, conv_valid;
    logic        chop_on, measuring, detect_flag, irq;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [71:0] ch_data;
    logic [7:0]  ch0_gain;
    int          n_fail, tests_run;

    gccd_top dut_u (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mod_tick(mod_tick),
        .chop_swap(chop_swap), .conv_valid(conv_valid), .ch_data(ch_data), .ch0_gain(ch0_gain),
        .chop_on(chop_on), .measuring(measuring), .detect_flag(detect_flag), .irq(irq));

    // 10 MHz clock
    always #50 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, n_fail);
    endtask

    // Bus write; both halves offered together, each dropped once taken
    task automatic axw(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    // Bus read with expected word and answer code
    task automatic axr(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One conversion every other cycle
    task automatic conv(input int n, input logic [23:0] a, input logic [23:0] b, input logic [23:0] c);
        repeat (n) begin
            ch_data <= {c, b, a};
            conv_valid <= 1'b1;
            @(posedge mclk);
            conv_valid <= 1'b0;
            @(posedge mclk);
        end
    endtask

    // Hang guard, far beyond the less than one thousand cycles the run needs
    initial begin
        #3000000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        logic [3:0] c;
        mclk = 0; nrst = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 10'h000; araddr = 10'h000; wdata = 32'h0; wstrb = 4'hF;
        mod_tick = 0; chop_swap = 0; conv_valid = 0; ch_data = 72'h0;
        n_fail = 0; tests_run = 0;
        wait_cyc(16);
        nrst <= 1'b1;
        @(posedge mclk);
        // Reset values and the unmapped hole
        axr(IDX_GAIN, 32'h0, RESP_OKAY);
        chk({24'h0, ch0_gain}, 32'h01);
        axr(IDX_RSVD, 32'h0, RESP_OKAY);
        axr(IDX_CFG, 32'h0600, RESP_OKAY);
        chk({31'h0, chop_on}, 32'h0);
        axr(IDX_TH_HIGH, 32'h0, RESP_OKAY);
        axr(IDX_TH_LOW, 32'h0, RESP_OKAY);
        axw(IDX_RSVD, 32'h0, RESP_OKAY);
        axw(8'h20, 32'h0, RESP_SLVERR);
        axr(8'h20, 32'h0, RESP_SLVERR);
        done("reset");
        // Every gain code, expected factor doubles per step
        for (int i = 0; i < 8; i++) begin
            axw(IDX_GAIN, i, RESP_OKAY);
            axr(IDX_GAIN, i, RESP_OKAY);
            chk({24'h0, ch0_gain}, 32'h1 << i);
        end
        done("gain");
        // Threshold words; upper lanes read as zero
        axw(IDX_TH_HIGH, 32'h1234A5C3, RESP_OKAY);
        axr(IDX_TH_HIGH, 32'h0000A5C3, RESP_OKAY);
        axw(IDX_TH_LOW, 32'h00003C00, RESP_OKAY);
        axr(IDX_TH_LOW, 32'h00003C00, RESP_OKAY);
        done("threshold");
        // Chop pause of 2^(code+1) ticks for the four shortest codes
        for (int k = 0; k < 4; k++) begin
            c = k;
            axw(IDX_CFG, {16'h0, 3'h0, c, 1'h1, 8'h00}, RESP_OKAY);
            chk({31'h0, chop_on}, 32'h1);
            chop_swap <= 1'b1;
            @(posedge mclk);
            chop_swap <= 1'b0;
            repeat ((2 << k) - 1) begin
                mod_tick <= 1'b1;
                @(posedge mclk);
                mod_tick <= 1'b0;
                @(posedge mclk);
            end
            chk({31'h0, measuring}, 32'h0);
            mod_tick <= 1'b1;
            @(posedge mclk);
            mod_tick <= 1'b0;
            wait_cyc(2);
            chk({31'h0, measuring}, 32'h1);
        end
        // Settled event: status, mask, level output, write-one clear
        axr(IDX_IRQ_STAT, 32'h2, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        axw(IDX_IRQ_MASK, 32'h3, RESP_OKAY);
        wait_cyc(1);
        chk({31'h0, irq}, 32'h1);
        axw(IDX_IRQ_STAT, 32'h2, RESP_OKAY);
        wait_cyc(1);
        chk({31'h0, irq}, 32'h0);
        axr(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
        done("chop");
        // Any-channel detection: threshold 256, need 2, window 128
        axw(IDX_TH_HIGH, 32'h0001, RESP_OKAY);
        axw(IDX_TH_LOW, 32'h0000, RESP_OKAY);
        axw(IDX_CFG, 32'h0611, RESP_OKAY);
        chop_swap <= 1'b1;
        @(posedge mclk);
        chop_swap <= 1'b0;
        wait_cyc(1);
        chk({31'h0, measuring}, 32'h1);
        conv(1, 24'h000100, 24'h0, 24'h0);
        conv(1, 24'h0, 24'h000101, 24'h0);
        conv(126, 24'h0, 24'h0, 24'h0);
        wait_cyc(4);
        chk({31'h0, detect_flag}, 32'h0);
        conv(1, 24'h0, 24'h0, 24'h000101);
        wait_cyc(4);
        chk({31'h0, detect_flag}, 32'h0);
        conv(1, 24'h0, 24'h0, 24'hFFFED4);
        wait_cyc(4);
        chk({31'h0, detect_flag}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        done("detect_any");
        // All-channel detection, need 1
        axw(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
        wait_cyc(1);
        chk({31'h0, detect_flag}, 32'h0);
        axw(IDX_CFG, 32'h0681, RESP_OKAY);
        conv(128, 24'h0, 24'h0, 24'h0);
        conv(1, 24'h7FFFFF, 24'h0, 24'h0);
        wait_cyc(4);
        chk({31'h0, detect_flag}, 32'h0);
        conv(1, 24'h7FFFFF, 24'h7FFFFF, 24'h7FFFFF);
        wait_cyc(4);
        chk({31'h0, detect_flag}, 32'h1);
        axr(IDX_LIVE, 32'hB, RESP_OKAY);
        done("detect_all");
        tally_and_finish();
    end
endmodule
